// [addr_map_pkg.sv]
// Address map constants and request/routed-request carriers for the system decoder.
// Assumes a flat 32-bit space; region bases are plain defaults, not fixed silicon values.
package addr_map_pkg;

  // Masters that can present a request
  typedef enum logic [1:0] {
    mst_core,
    mst_dma,
    mst_pci,
    mst_periph
  } master_t;

  // Decoded targets
  typedef enum logic [3:0] {
    tgt_none,
    tgt_l1_instr,
    tgt_l1_data_a,
    tgt_l1_data_b,
    tgt_scratch,
    tgt_l2,
    tgt_sdram,
    tgt_async,
    tgt_pci_mem,
    tgt_pci_io,
    tgt_pci_cfg,
    tgt_core_reg,
    tgt_sys_reg
  } target_t;

  // Request from a master
  typedef struct packed {
    logic        valid;
    master_t     master;
    logic        supervisor;
    logic        write;
    logic        instr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } req_t;

  // Routed request to a target
  typedef struct packed {
    logic        valid;
    target_t     target;
    logic [1:0]  bank;
    logic        wide_path;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } route_t;

  // Region bases and sizes (byte addresses)
  localparam logic [31:0] sdram_base     = 32'h0000_0000;
  localparam logic [31:0] async_base     = 32'h2000_0000;
  localparam logic [31:0] async_seg      = 32'h0400_0000;
  localparam logic [31:0] async_end      = 32'h3000_0000;
  localparam logic [31:0] pci_cfg_addr   = 32'heeff_fff8;
  localparam logic [31:0] pci_cfg_data   = 32'heeff_fffc;
  localparam logic [31:0] pci_io_base    = 32'heefe_0000;
  localparam logic [31:0] pci_io_size    = 32'h0001_0000;
  localparam logic [31:0] pci_mem_base   = 32'he000_0000;
  localparam logic [31:0] pci_mem_size   = 32'h0800_0000;
  localparam logic [31:0] l2_base        = 32'hf000_0000;
  localparam logic [31:0] l2_size        = 32'h0004_0000;
  localparam logic [31:0] l1_data_a_base = 32'hff80_0000;
  localparam logic [31:0] l1_data_b_base = 32'hff90_0000;
  localparam logic [31:0] l1_instr_base  = 32'hffa0_0000;
  localparam logic [31:0] l1_bank_size   = 32'h0000_4000;
  localparam logic [31:0] scratch_base   = 32'hffb0_0000;
  localparam logic [31:0] scratch_size   = 32'h0000_1000;
  localparam logic [31:0] sys_reg_base   = 32'hffc0_0000;
  localparam logic [31:0] core_reg_base  = 32'hffe0_0000;
  localparam logic [31:0] reg_blk_size   = 32'h0020_0000;

  // SDRAM bank size codes: 16, 32, 64, 128 Mbyte
  localparam logic [31:0] sdram_unit     = 32'h0100_0000;
  localparam int          sdram_banks    = 4;

endpackage : addr_map_pkg

// [sdram_bank_map.sv]
// Computes contiguous SDRAM bank bounds from per-bank size codes.
// Assumes size codes are static while requests are in flight.
`timescale 1ns/1ps
module sdram_bank_map (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Bank configuration: 2 bits per bank, size = 16M << code
  input  wire logic [7:0]  size_code,
  // Registered end address of each bank (exclusive)
  output logic      [31:0] bank_end_q [4]
);

  logic [31:0] end_d [4];

  // Each bank starts where the previous one ends
  generate
    for (genvar b = 0; b < addr_map_pkg::sdram_banks; b++) begin : g_bank
      logic [31:0] prev;
      if (b == 0) begin : g_first
        assign prev = addr_map_pkg::sdram_base;
      end else begin : g_rest
        assign prev = end_d[b-1];
      end
      assign end_d[b] = prev + (addr_map_pkg::sdram_unit << size_code[2*b +: 2]);

      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          bank_end_q[b] <= 32'h0000_0000;
        end else begin
          bank_end_q[b] <= end_d[b];
        end
      end
    end
  endgenerate

endmodule : sdram_bank_map

// [system_address_decoder.sv]
// System address decoder: routes one request per cycle to its target region.
// Assumes masters hold no request during reset and present identity and privilege.
// Overview of operation
// - Flat 32-bit address space, disjoint regions
// - Up to four SDRAM banks, 16-128 Mbyte
// - SDRAM banks packed back to back
// - Gap below async base is reserved
// - Four async banks of fixed 64 Mbyte
// - 128 Mbyte window to relocatable PCI memory
// - 64 Kbyte window to relocatable PCI I/O
// - Fixed two-word PCI configuration window (address word, data word)
// - Register blocks near top of space
// - Core registers: supervisor core only
// - System registers: optional visibility for others
// - Scratch pad: core data only, no DMA
// - Core 64-bit path into L2
// - L1 banks selectable SRAM or cache way
// - DMA reaches L1, L2 and external spaces
`timescale 1ns/1ps
module system_address_decoder (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // Request from the arbitrated master
  input  wire addr_map_pkg::req_t          req,
  // Configuration
  input  wire logic [7:0]                  sdram_size_code,
  input  wire logic                        sys_reg_visible,
  input  wire logic [31:0]                 pci_mem_remap,
  input  wire logic [31:0]                 pci_io_remap,
  input  wire logic                        l1_data_a_cache,
  input  wire logic                        l1_data_b_cache,
  input  wire logic                        l1_instr_cache,
  // Routed request
  output addr_map_pkg::route_t             route_q,
  // Access error to requester
  output logic                             err_q,
  output addr_map_pkg::master_t            err_master_q,
  // PCI configuration window state
  output logic [31:0]                      cfg_target_q,
  output logic                             cfg_pending_q
);

  logic [31:0]           bank_end [4];
  addr_map_pkg::target_t tgt;
  logic [1:0]            bank;
  logic [31:0]           xaddr;
  logic                  deny;
  logic [31:0]           a;

  assign a = req.addr;

  sdram_bank_map u_bank_map (
    .clk       (clk),
    .nrst      (nrst),
    .size_code (sdram_size_code),
    .bank_end_q(bank_end)
  );

  // Region decode; priority is irrelevant as regions never overlap
  always_comb begin
    tgt   = addr_map_pkg::tgt_none;
    bank  = 2'h0;
    xaddr = a;
    if (a < bank_end[3]) begin
      tgt = addr_map_pkg::tgt_sdram;
      if (a >= bank_end[2]) begin
        bank  = 2'h3;
        xaddr = a - bank_end[2];
      end else if (a >= bank_end[1]) begin
        bank  = 2'h2;
        xaddr = a - bank_end[1];
      end else if (a >= bank_end[0]) begin
        bank  = 2'h1;
        xaddr = a - bank_end[0];
      end else begin
        xaddr = a - addr_map_pkg::sdram_base;
      end
    end else if (a < addr_map_pkg::async_base) begin
      tgt = addr_map_pkg::tgt_none;
    end else if (a < addr_map_pkg::async_end) begin
      tgt   = addr_map_pkg::tgt_async;
      bank  = a[27:26];
      xaddr = {6'h00, a[25:0]};
    end else if (a >= addr_map_pkg::pci_mem_base &&
                 a < addr_map_pkg::pci_mem_base + addr_map_pkg::pci_mem_size) begin
      tgt   = addr_map_pkg::tgt_pci_mem;
      xaddr = pci_mem_remap + (a - addr_map_pkg::pci_mem_base);
    end else if (a >= addr_map_pkg::pci_io_base &&
                 a < addr_map_pkg::pci_io_base + addr_map_pkg::pci_io_size) begin
      tgt   = addr_map_pkg::tgt_pci_io;
      xaddr = pci_io_remap + (a - addr_map_pkg::pci_io_base);
    end else if (a == addr_map_pkg::pci_cfg_addr || a == addr_map_pkg::pci_cfg_data) begin
      tgt = addr_map_pkg::tgt_pci_cfg;
    end else if (a >= addr_map_pkg::l2_base &&
                 a < addr_map_pkg::l2_base + addr_map_pkg::l2_size) begin
      tgt   = addr_map_pkg::tgt_l2;
      xaddr = a - addr_map_pkg::l2_base;
    end else if (a >= addr_map_pkg::l1_data_a_base &&
                 a < addr_map_pkg::l1_data_a_base + addr_map_pkg::l1_bank_size) begin
      tgt   = addr_map_pkg::tgt_l1_data_a;
      xaddr = a - addr_map_pkg::l1_data_a_base;
    end else if (a >= addr_map_pkg::l1_data_b_base &&
                 a < addr_map_pkg::l1_data_b_base + addr_map_pkg::l1_bank_size) begin
      tgt   = addr_map_pkg::tgt_l1_data_b;
      xaddr = a - addr_map_pkg::l1_data_b_base;
    end else if (a >= addr_map_pkg::l1_instr_base &&
                 a < addr_map_pkg::l1_instr_base + addr_map_pkg::l1_bank_size) begin
      tgt   = addr_map_pkg::tgt_l1_instr;
      xaddr = a - addr_map_pkg::l1_instr_base;
    end else if (a >= addr_map_pkg::scratch_base &&
                 a < addr_map_pkg::scratch_base + addr_map_pkg::scratch_size) begin
      tgt   = addr_map_pkg::tgt_scratch;
      xaddr = a - addr_map_pkg::scratch_base;
    end else if (a >= addr_map_pkg::sys_reg_base &&
                 a < addr_map_pkg::sys_reg_base + addr_map_pkg::reg_blk_size) begin
      tgt   = addr_map_pkg::tgt_sys_reg;
      xaddr = a - addr_map_pkg::sys_reg_base;
    end else if (a >= addr_map_pkg::core_reg_base) begin
      // Core block runs to the top of the space; base plus size would wrap to zero
      tgt   = addr_map_pkg::tgt_core_reg;
      xaddr = a - addr_map_pkg::core_reg_base;
    end
  end

  // Access checks; a cache-configured L1 bank is not directly addressable
  always_comb begin
    deny = 1'b0;
    case (tgt)
      addr_map_pkg::tgt_none: begin
        deny = 1'b1;
      end
      addr_map_pkg::tgt_core_reg: begin
        deny = !(req.master == addr_map_pkg::mst_core && req.supervisor);
      end
      addr_map_pkg::tgt_sys_reg: begin
        if (req.master == addr_map_pkg::mst_core) begin
          deny = !req.supervisor;
        end else begin
          deny = !sys_reg_visible;
        end
      end
      addr_map_pkg::tgt_scratch: begin
        deny = req.master != addr_map_pkg::mst_core || req.instr;
      end
      addr_map_pkg::tgt_l1_data_a: begin
        deny = l1_data_a_cache || req.instr || req.master == addr_map_pkg::mst_pci;
      end
      addr_map_pkg::tgt_l1_data_b: begin
        deny = l1_data_b_cache || req.instr || req.master == addr_map_pkg::mst_pci;
      end
      addr_map_pkg::tgt_l1_instr: begin
        deny = l1_instr_cache || req.master == addr_map_pkg::mst_pci;
      end
      default: begin
        deny = 1'b0;
      end
    endcase
  end

  // Routed request; refused requests never reach a target
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      route_q <= '0;
    end else begin
      route_q.valid     <= req.valid && !deny;
      route_q.target    <= deny ? addr_map_pkg::tgt_none : tgt;
      route_q.bank      <= bank;
      route_q.wide_path <= tgt == addr_map_pkg::tgt_l2 &&
                           req.master == addr_map_pkg::mst_core;
      route_q.write     <= req.write;
      route_q.addr      <= xaddr;
      route_q.wdata     <= req.wdata;
    end
  end

  // Error indication, one cycle per refused request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      err_q        <= 1'b0;
      err_master_q <= addr_map_pkg::mst_core;
    end else begin
      err_q        <= req.valid && deny;
      err_master_q <= req.master;
    end
  end

  // PCI configuration window: address latch, then data access
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_target_q  <= 32'h0000_0000;
      cfg_pending_q <= 1'b0;
    end else if (req.valid && !deny && tgt == addr_map_pkg::tgt_pci_cfg) begin
      if (a == addr_map_pkg::pci_cfg_addr && req.write) begin
        cfg_target_q <= req.wdata;
      end
      cfg_pending_q <= a == addr_map_pkg::pci_cfg_data;
    end else begin
      cfg_pending_q <= 1'b0;
    end
  end

endmodule : system_address_decoder

// [system_address_decoder_assertions.sv]
// Concurrent checks on the system address decoder ports.
// Assumes one clock domain with the asynchronous active-low reset nrst.
`timescale 1ns/1ps
module system_address_decoder_checker (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  nrst,
  // Observed ports
  input wire addr_map_pkg::req_t    req,
  input wire logic                  sys_reg_visible,
  input wire logic [31:0]           pci_mem_remap,
  input wire addr_map_pkg::route_t  route_q,
  input wire logic                  err_q,
  input wire addr_map_pkg::master_t err_master_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Every taken request gets exactly one kind of answer, one cycle later
  property p_answer; req.valid |=> route_q.valid != err_q; endproperty
  a_answer: assert property (p_answer) else $error("no single answer");
  property p_quiet; !req.valid |=> !route_q.valid && !err_q; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");
  property p_core_reg; req.valid && req.addr[31:21] == 11'h7ff &&
    !(req.master == addr_map_pkg::mst_core && req.supervisor) |=> err_q; endproperty
  a_core_reg: assert property (p_core_reg) else $error("core block reached");
  property p_sys_reg; req.valid && req.addr[31:21] == 11'h7fe && !sys_reg_visible &&
    req.master != addr_map_pkg::mst_core |=> err_q; endproperty
  a_sys_reg: assert property (p_sys_reg) else $error("system block reached");
  property p_scratch; req.valid && req.master == addr_map_pkg::mst_dma &&
    req.addr[31:12] == 20'hffb00 |=> err_q; endproperty
  a_scratch: assert property (p_scratch) else $error("scratch reached by dma");
  // Fixed 64 Mbyte segments: bank is address bits 27:26
  property p_async; req.valid && req.addr[31:28] == 4'h2 |=>
    route_q.target == addr_map_pkg::tgt_async && route_q.bank == $past(req.addr[27:26])
    && route_q.addr == {6'h00, $past(req.addr[25:0])}; endproperty
  a_async: assert property (p_async) else $error("async bank decode wrong");
  property p_pci_mem; req.valid && req.master == addr_map_pkg::mst_core &&
    req.addr[31:27] == 5'h1c |=> route_q.target == addr_map_pkg::tgt_pci_mem &&
    route_q.addr == $past(pci_mem_remap) + {5'h00, $past(req.addr[26:0])}; endproperty
  a_pci_mem: assert property (p_pci_mem) else $error("pci memory window wrong");
  property p_l2_wide; req.valid && req.master == addr_map_pkg::mst_core &&
    req.addr[31:18] == 14'h3c00 |=> route_q.wide_path; endproperty
  a_l2_wide: assert property (p_l2_wide) else $error("core l2 path not wide");
  property p_err_master; err_q |-> err_master_q == $past(req.master); endproperty
  a_err_master: assert property (p_err_master) else $error("error master wrong");
  // Main scenarios reached
  c_async: cover property (route_q.valid && route_q.target == addr_map_pkg::tgt_async);
  c_err: cover property (err_q);
  c_sys: cover property (route_q.valid && route_q.target == addr_map_pkg::tgt_sys_reg);
endmodule : system_address_decoder_checker

bind system_address_decoder system_address_decoder_checker u_system_address_decoder_checker (
  .clk(clk), .nrst(nrst), .req(req), .sys_reg_visible(sys_reg_visible),
  .pci_mem_remap(pci_mem_remap), .route_q(route_q), .err_q(err_q), .err_master_q(err_master_q));

// [bus_master_model.sv]
// Behavioural requester standing in for core, memory DMA and PCI masters.
// Assumes the bench calls send from one process, one request at a time.
`timescale 1ns/1ps
module bus_master_model (
  // Clock
  input  wire logic          clk,
  // Request toward the decoder
  output addr_map_pkg::req_t req
);
  initial req = '0;
  // Identity and privilege travel with every request
  task automatic send(addr_map_pkg::master_t m, logic s, logic w, logic i,
                      logic [31:0] a, logic [31:0] d);
    @(posedge clk);
    req <= '{1'b1, m, s, w, i, a, d};
    @(posedge clk);
    req.valid <= 1'b0;
    req.addr  <= ~a; // Released address must not look like the last one
  endtask : send
endmodule : bus_master_model

// [tb.sv]
// Self-checking bench for the system address decoder.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
module tb;
  logic                  clk = 1'b0;
  logic                  nrst = 1'b0;
  addr_map_pkg::req_t    req;
  logic [7:0]            size_code = 8'h00;
  logic                  vis = 1'b0;
  logic [2:0]            cache = 3'h0;
  logic [31:0]           mem_remap = 32'h4000_0000;
  logic [31:0]           io_remap = 32'h0000_1000;
  addr_map_pkg::route_t  route_q;
  logic                  err_q;
  addr_map_pkg::master_t err_master_q;
  logic [31:0]           cfg_target_q;
  logic                  cfg_pending_q;
  int                    n_fail = 0;
  int                    n_compared = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  bus_master_model u_bus_master_model (.clk(clk), .req(req));
  system_address_decoder u_system_address_decoder (
    .clk(clk), .nrst(nrst), .req(req), .sdram_size_code(size_code), .sys_reg_visible(vis),
    .pci_mem_remap(mem_remap), .pci_io_remap(io_remap),
    .l1_data_a_cache(cache[0]), .l1_data_b_cache(cache[1]), .l1_instr_cache(cache[2]),
    .route_q(route_q), .err_q(err_q), .err_master_q(err_master_q),
    .cfg_target_q(cfg_target_q), .cfg_pending_q(cfg_pending_q));
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One request; answer sampled just after the taking edge
  task automatic xfer(addr_map_pkg::master_t m, logic s, logic w, logic i, logic [31:0] a,
                      logic [31:0] d, addr_map_pkg::target_t t);
    u_bus_master_model.send(m, s, w, i, a, d);
    #1;
    check("target", route_q.target, t);
    check("error", err_q, t == addr_map_pkg::tgt_none);
    check("valid", route_q.valid, t != addr_map_pkg::tgt_none);
  endtask : xfer
  task automatic t_async();
    for (int b = 0; b < 4; b++) begin
      xfer(addr_map_pkg::mst_core, 1, 0, 0, 32'h2000_0010 + b * 32'h0400_0000, 0,
           addr_map_pkg::tgt_async);
      check("async bank", route_q.bank, b);
      check("async offset", route_q.addr, 32'h10);
    end
    $display("async test done");
  endtask : t_async
  // Banks of 16, 32, 64 and 128 Mbyte packed back to back
  task automatic t_sdram();
    @(posedge clk) size_code <= 8'he4;
    xfer(addr_map_pkg::mst_dma, 0, 0, 0, 32'h0300_0004, 0, addr_map_pkg::tgt_sdram);
    check("sdram bank", route_q.bank, 2);
    xfer(addr_map_pkg::mst_dma, 0, 0, 0, 32'h0eff_fffc, 0, addr_map_pkg::tgt_sdram);
    check("sdram offset", route_q.addr, 32'h07ff_fffc);
    xfer(addr_map_pkg::mst_core, 1, 0, 0, 32'h0f00_0000, 0, addr_map_pkg::tgt_none);
    $display("sdram test done");
  endtask : t_sdram
  task automatic t_pci();
    xfer(addr_map_pkg::mst_dma, 0, 0, 0, 32'he000_0100, 0, addr_map_pkg::tgt_pci_mem);
    check("pci mem addr", route_q.addr, 32'h4000_0100);
    xfer(addr_map_pkg::mst_core, 1, 0, 0, 32'heefe_0020, 0, addr_map_pkg::tgt_pci_io);
    check("pci io addr", route_q.addr, 32'h0000_1020);
    // Move both windows on the PCI side; near the end of the memory window, last word of the I/O window
    @(posedge clk) begin
      mem_remap <= 32'h8000_0000;
      io_remap  <= 32'hffff_0000;
    end
    xfer(addr_map_pkg::mst_core, 1, 0, 0, 32'he7ff_fff0, 0, addr_map_pkg::tgt_pci_mem);
    check("pci mem end", route_q.addr, 32'h87ff_fff0);
    xfer(addr_map_pkg::mst_dma, 0, 0, 0, 32'heefe_fffc, 0, addr_map_pkg::tgt_pci_io);
    check("pci io end", route_q.addr, 32'hffff_fffc);
    xfer(addr_map_pkg::mst_core, 1, 1, 0, addr_map_pkg::pci_cfg_addr, 32'h0000_0804,
         addr_map_pkg::tgt_pci_cfg);
    check("cfg target", cfg_target_q, 32'h0000_0804);
    check("cfg write", route_q.write, 1);
    check("cfg wdata", route_q.wdata, 32'h0000_0804);
    xfer(addr_map_pkg::mst_core, 1, 0, 0, addr_map_pkg::pci_cfg_data, 0,
         addr_map_pkg::tgt_pci_cfg);
    check("cfg pending", cfg_pending_q, 1);
    $display("pci test done");
  endtask : t_pci
  task automatic t_protect();
    xfer(addr_map_pkg::mst_core, 0, 0, 0, 32'hffe0_0000, 0, addr_map_pkg::tgt_none);
    check("error master", err_master_q, addr_map_pkg::mst_core);
    xfer(addr_map_pkg::mst_pci, 1, 0, 0, 32'hffe0_0100, 0, addr_map_pkg::tgt_none);
    xfer(addr_map_pkg::mst_core, 1, 0, 0, 32'hffe0_0100, 0, addr_map_pkg::tgt_core_reg);
    xfer(addr_map_pkg::mst_dma, 0, 0, 0, 32'hffc0_0040, 0, addr_map_pkg::tgt_none);
    @(posedge clk) vis <= 1'b1;
    xfer(addr_map_pkg::mst_dma, 0, 0, 0, 32'hffc0_0040, 0, addr_map_pkg::tgt_sys_reg);
    xfer(addr_map_pkg::mst_core, 0, 0, 0, 32'hffc0_0040, 0, addr_map_pkg::tgt_none);
    xfer(addr_map_pkg::mst_dma, 0, 0, 0, 32'hffb0_0010, 0, addr_map_pkg::tgt_none);
    xfer(addr_map_pkg::mst_core, 1, 0, 1, 32'hffb0_0010, 0, addr_map_pkg::tgt_none);
    xfer(addr_map_pkg::mst_core, 1, 0, 0, 32'hffb0_0010, 0, addr_map_pkg::tgt_scratch);
    $display("protection test done");
  endtask : t_protect
  task automatic t_mem();
    @(posedge clk) cache <= 3'h1;
    xfer(addr_map_pkg::mst_core, 1, 0, 0, 32'hff80_0000, 0, addr_map_pkg::tgt_none);
    @(posedge clk) cache <= 3'h6;
    xfer(addr_map_pkg::mst_core, 1, 0, 0, 32'hff90_0000, 0, addr_map_pkg::tgt_none);
    xfer(addr_map_pkg::mst_core, 1, 0, 1, 32'hffa0_0000, 0, addr_map_pkg::tgt_none);
    @(posedge clk) cache <= 3'h0;
    xfer(addr_map_pkg::mst_core, 1, 0, 0, 32'hff80_0000, 0, addr_map_pkg::tgt_l1_data_a);
    xfer(addr_map_pkg::mst_core, 1, 0, 1, 32'hffa0_0000, 0, addr_map_pkg::tgt_l1_instr);
    xfer(addr_map_pkg::mst_core, 1, 0, 1, 32'hff80_0000, 0, addr_map_pkg::tgt_none);
    xfer(addr_map_pkg::mst_pci, 0, 0, 0, 32'hff90_0000, 0, addr_map_pkg::tgt_none);
    xfer(addr_map_pkg::mst_dma, 0, 0, 0, 32'hff90_0000, 0, addr_map_pkg::tgt_l1_data_b);
    xfer(addr_map_pkg::mst_core, 1, 0, 1, 32'hf000_0100, 0, addr_map_pkg::tgt_l2);
    check("wide path", route_q.wide_path, 1);
    check("l2 offset", route_q.addr, 32'h0000_0100);
    xfer(addr_map_pkg::mst_core, 1, 0, 0, 32'h5000_0000, 0, addr_map_pkg::tgt_none);
    $display("memory test done");
  endtask : t_mem
  task automatic print_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  // Main sequence: two cycles of reset, then the scenarios
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    t_async();
    t_sdram();
    t_pci();
    t_protect();
    t_mem();
    print_verdict();
  end
  // Watchdog well beyond the roughly 75 cycles the scenarios need
  initial begin
    #20000;
    n_fail++;
    print_verdict();
  end
endmodule : tb
